// *** core/ifd_pkg.sv ***
// field layout, codes and output carrier for the instruction field decoder
// assumes one processor clock
package ifd_pkg;

    // ------------------------------------------------------------
    // word layout
    // ------------------------------------------------------------
    localparam int WORD_W = 36;      // instruction word width
    localparam int MOD_W = 18;       // modifier / increment width
    localparam int IND_SUB_W = 22;   // bits replaced by an indirect word
    localparam int EXT_LSB = 26;     // low bit of the extended opcode

    // instruction word, most significant field first
    typedef struct packed {
        logic [5:0] op;       // operation code
        logic [3:0] sel;      // operand selector / minor code
        logic [3:0] rs;       // register select
        logic [3:0] ix;       // index select
        logic inc;            // increment flag
        logic ind;            // indirect flag
        logic [15:0] base;    // base address
    } ifd_instr_s;

    // ------------------------------------------------------------
    // codes and fixed addresses
    // ------------------------------------------------------------
    localparam logic [3:0] SEL_IMM = 4'he;      // operand from word, zero fill
    localparam logic [3:0] SEL_IMM_SX = 4'hf;   // operand from word, sign fill
    localparam logic [3:0] SEL_SX_LO = 4'h3;    // first sign-extended selector
    localparam logic [3:0] SEL_SX_HI = 4'h7;    // last sign-extended partial-word selector
    localparam logic [3:0] IX_NONE = 4'h0;      // no address modification
    localparam logic [15:0] ERR_VEC = 16'h00c0; // error handler entry
    localparam logic [15:0] ACW_LO = 16'h0020;  // first access-control word
    localparam logic [15:0] ACW_HI = 16'h003f;  // last access-control word

    // partial word class
    typedef enum logic [2:0] {
        PART_WHOLE = 3'h0,
        PART_HALF = 3'h1,
        PART_THIRD = 3'h2,
        PART_SIXTH = 3'h3,
        PART_IMM = 3'h4
    } ifd_part_e;

    // group chosen by the operation code
    typedef enum logic [1:0] {
        GRP_ARITH = 2'h0,
        GRP_INDEX = 2'h1,
        GRP_IO = 2'h2,
        GRP_R = 2'h3
    } ifd_grp_e;

    // dedicated R-register functions
    typedef enum logic [2:0] {
        RFN_RTC = 3'h0,
        RFN_RPT = 3'h1,
        RFN_MASK = 3'h2,
        RFN_TPA = 3'h3,
        RFN_GEN = 3'h4
    } ifd_rfn_e;

    // sequencer states, one-hot
    typedef enum logic [2:0] {
        ST_IDLE = 3'b001,
        ST_XWAIT = 3'b010,
        ST_IWAIT = 3'b100
    } ifd_state_e;

    // decoded result toward the execution side
    typedef struct packed {
        logic valid;          // one-cycle strobe
        logic fault;          // undefined code
        logic [5:0] op;
        logic ext;            // selector used as minor code
        logic [9:0] ext_op;
        logic [3:0] sel;
        ifd_part_e part;
        logic [2:0] part_idx; // piece number, 0 = lowest
        logic sext;           // replicate partial msb upward
        logic from_instr;     // operand is in the word itself
        logic store_inh;      // no store toward core memory
        logic mem_rd;         // operand read needed
        ifd_grp_e grp;
        logic [3:0] rnum;
        ifd_rfn_e rfn;
        logic ij;             // index jump
        logic [7:0] ij_addr;  // control-memory address for index jump
        logic acw_hit;        // general access hits access-control words
        logic shift;
        logic lock;
        logic [15:0] aux;     // shift count or section selector
        logic [15:0] ea;      // effective address
        logic [35:0] imm;     // operand from the instruction
        logic tpa_save;       // save next address in temporary register
        logic [15:0] tpa_addr;
    } ifd_dec_s;

endpackage

// *** core/ifd_oc_add.sv ***
// one's complement adder with end-around carry
// purely combinational, used by the decoder for indexing and increment
module ifd_oc_add #(
    parameter int W = 18
) (
    // operands
    input wire logic [W-1:0] i_a,
    input wire logic [W-1:0] i_b,
    // result
    output logic [W-1:0] o_sum
);
    // carry out of the top wraps into the bottom
    logic [W:0] raw;

    // ------------------------------------------------------------
    // elaboration check
    // ------------------------------------------------------------
    if (W < 2) begin : g_chk
        $error("adder width too small");
    end

    // ------------------------------------------------------------
    // add and fold carry
    // ------------------------------------------------------------
    // a second carry cannot arise, so one fold is enough
    always_comb begin
        raw = {1'b0, i_a} + {1'b0, i_b};
        o_sum = raw[W-1:0] + {{(W-1){1'b0}}, raw[W]};
    end
endmodule

// *** core/ifd_decoder.sv ***
// instruction field decoder: splits and interprets one instruction word
// assumes index and indirect words answer by request/acknowledge
//
// Contract
// - split word into seven fixed fields
// - ten top bits form extended opcode
// - undefined codes fault, jump to error address
// - selectors 16, 17 take operand from word
// - selectors 3..7, 17 replicate partial msb
// - halves, thirds, sixths; thirds extend, sixths never
// - selectors 16, 17 suppress store path
// - register select meaning depends on instruction
// - index jump joins register and operand selects
// - index select zero disables modification
// - increment flag adds increment to modifier
// - indirect replaces low 22 bits, cascades
// - effective address from modified base address
// - base gives shift count or lockout section
// - group by instruction, member by value
// - R values 0..3 select dedicated registers
// - mask register is a plain data word
// - save next address only while repeating
// - locations 32..63 kept for access words
// - index word: increment high, modifier low
// - zero-extend base, 18-bit one's complement add
// - loop back to indexing until direct
module ifd_decoder #(
    parameter logic [63:0] DEF_OPS = 64'hffff_ffff_ffff_fffe,
    parameter logic [63:0] EXT_OPS = 64'h7000_0000_0000_0000,
    parameter logic [15:0] MINOR_DEF = 16'h00ff,
    parameter logic [63:0] SHIFT_OPS = 64'h0000_0000_0f00_0000,
    parameter logic [63:0] LOCK_OPS = 64'h0000_0000_1000_0000,
    parameter logic [63:0] IDXA_OPS = 64'h0000_0000_00e0_0000,
    parameter logic [63:0] IO_OPS = 64'h0000_00ff_0000_0000,
    parameter logic [63:0] R_OPS = 64'h0000_0f00_0000_0000,
    parameter logic [5:0] IJ_OP = 6'h34
) (
    // clock and reset
    input wire logic i_sys_clk,
    input wire logic i_reset_n,
    // instruction in
    input wire logic i_ir_valid,
    input wire logic [35:0] i_ir_word,
    output logic o_ir_ready,
    // index register access
    output logic o_xr_req,
    output logic [3:0] o_xr_sel,
    input wire logic i_xr_ack,
    input wire logic [35:0] i_xr_word,
    output logic o_xr_wr,
    output logic [17:0] o_xr_wmod,
    // indirect word fetch
    output logic o_ind_req,
    output logic [15:0] o_ind_addr,
    input wire logic i_ind_ack,
    input wire logic [35:0] i_ind_word,
    // repeat sequence
    input wire logic i_rpt_active,
    input wire logic [15:0] i_next_pa,
    // decoded result
    output ifd_pkg::ifd_dec_s o_dec
);
    import ifd_pkg::*;

    // whole state of the decoder
    typedef struct packed {
        ifd_state_e st;
        logic ready;
        ifd_instr_s ir;       // word under work
        logic xr_req;
        logic [3:0] xr_sel;
        logic xr_wr;
        logic [17:0] xr_wmod;
        logic ind_req;
        logic [15:0] ind_addr;
        ifd_dec_s dec;
    } ifd_st_s;

    ifd_st_s st_r;            // registered state
    ifd_st_s st_nxt;          // next state
    logic [1:0] rst_sync_r;   // reset release chain
    logic rst_n;              // synchronised reset
    logic [17:0] addr_sum;    // base plus modifier
    logic [17:0] inc_sum;     // modifier plus increment

    // ------------------------------------------------------------
    // elaboration check
    // ------------------------------------------------------------
    if (!DEF_OPS[IJ_OP] || (SHIFT_OPS & LOCK_OPS) != 64'h0) begin : g_chk
        $error("inconsistent opcode tables");
    end

    // ------------------------------------------------------------
    // reset release
    // ------------------------------------------------------------
    // assert at once, release on the clock
    always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            rst_sync_r <= 2'b00;
        end else begin
            rst_sync_r <= {rst_sync_r[0], 1'b1};
        end
    end
    assign rst_n = rst_sync_r[1];

    // ------------------------------------------------------------
    // index arithmetic
    // ------------------------------------------------------------
    // modifier sits low, increment high in the index word
    ifd_oc_add #(.W(MOD_W)) u_addr_add (
        .i_a({2'b00, st_r.ir.base}),
        .i_b(i_xr_word[MOD_W-1:0]),
        .o_sum(addr_sum)
    );
    ifd_oc_add #(.W(MOD_W)) u_inc_add (
        .i_a(i_xr_word[MOD_W-1:0]),
        .i_b(i_xr_word[WORD_W-1:MOD_W]),
        .o_sum(inc_sum)
    );

    // ------------------------------------------------------------
    // field interpretation
    // ------------------------------------------------------------
    // undefined opcode or undefined minor code
    function automatic logic is_fault(input ifd_instr_s w);
        is_fault = !DEF_OPS[w.op] || (EXT_OPS[w.op] && !MINOR_DEF[w.sel]);
    endfunction

    // m: modified low 18 bits, ea18: address sum
    function automatic ifd_dec_s decode(input ifd_instr_s w, input logic [17:0] m,
                                        input logic [17:0] ea18);
        ifd_dec_s d;
        logic part_ok;
        d = '0;
        d.valid = 1'b1;
        d.fault = is_fault(w);
        d.op = w.op;
        d.sel = w.sel;
        d.rnum = w.rs;
        d.ext = EXT_OPS[w.op] || (w.op == IJ_OP);
        d.ext_op = {w.op, w.sel};
        d.ij = (w.op == IJ_OP);
        d.ij_addr = {w.rs, w.sel};
        d.shift = SHIFT_OPS[w.op];
        d.lock = LOCK_OPS[w.op];
        d.aux = w.base;
        part_ok = !d.ext;
        d.part = PART_WHOLE;
        // selector table: halves 1..4, thirds 5..7, sixths 8..13
        if (part_ok) begin
            if (w.sel == 4'h0) begin
                d.part = PART_WHOLE;
            end else if (w.sel <= 4'h4) begin
                d.part = PART_HALF;
                d.part_idx = {2'b00, ~w.sel[0]};
            end else if (w.sel <= 4'h7) begin
                d.part = PART_THIRD;
                d.part_idx = 3'(w.sel - 4'h5);
            end else if (w.sel <= 4'hd) begin
                d.part = PART_SIXTH;
                d.part_idx = 3'(w.sel - 4'h8);
            end else begin
                d.part = PART_IMM;
            end
            // thirds always, sixths never, halves only on 3 and 4
            d.sext = (w.sel >= SEL_SX_LO && w.sel <= SEL_SX_HI) ||
                     (w.sel == SEL_IMM_SX);
            d.from_instr = (w.sel == SEL_IMM) || (w.sel == SEL_IMM_SX);
        end
        d.store_inh = d.from_instr;
        d.imm = d.sext ? {{18{m[17]}}, m} : {18'h0, m};
        d.mem_rd = !d.fault && !d.from_instr && !d.shift && !d.lock;
        // group by instruction class, member by field value
        if (IDXA_OPS[w.op]) begin
            d.grp = GRP_INDEX;
        end else if (IO_OPS[w.op]) begin
            d.grp = GRP_IO;
        end else if (R_OPS[w.op]) begin
            d.grp = GRP_R;
        end else begin
            d.grp = GRP_ARITH;
        end
        // the mask register carries plain data, no control format
        if (w.rs <= 4'h3) begin
            d.rfn = ifd_rfn_e'({1'b0, w.rs[1:0]});
        end else begin
            d.rfn = RFN_GEN;
        end
        d.ea = d.fault ? ERR_VEC : ea18[15:0];
        // io words belong to io instructions
        d.acw_hit = d.mem_rd && d.grp != GRP_IO && d.ea >= ACW_LO &&
                    d.ea <= ACW_HI;
        d.tpa_save = i_rpt_active;
        d.tpa_addr = i_rpt_active ? i_next_pa : 16'h0;
        return d;
    endfunction

    // ------------------------------------------------------------
    // sequencer
    // ------------------------------------------------------------
    always_comb begin
        ifd_instr_s cur;
        logic go;
        logic fin;
        logic [17:0] m;
        logic [17:0] ea18;
        cur = st_r.ir;
        go = 1'b0;
        fin = 1'b0;
        m = '0;
        ea18 = '0;
        st_nxt = st_r;
        st_nxt.xr_wr = 1'b0;
        st_nxt.dec.valid = 1'b0;
        st_nxt.dec.tpa_save = 1'b0;
        case (st_r.st)
            // accept a new word
            ST_IDLE: begin
                if (i_ir_valid && st_r.ready) begin
                    cur = i_ir_word;
                    go = 1'b1;
                end
            end
            // index word arrives: modify, maybe write back
            ST_XWAIT: begin
                if (i_xr_ack) begin
                    st_nxt.xr_req = 1'b0;
                    m = addr_sum;
                    ea18 = addr_sum;
                    if (cur.inc) begin
                        st_nxt.xr_wr = 1'b1;
                        st_nxt.xr_wmod = inc_sum;
                    end
                    if (cur.ind) begin
                        st_nxt.st = ST_IWAIT;
                        st_nxt.ind_req = 1'b1;
                        st_nxt.ind_addr = addr_sum[15:0];
                    end else begin
                        fin = 1'b1;
                    end
                end
            end
            // indirect word arrives: substitute and start over
            ST_IWAIT: begin
                if (i_ind_ack) begin
                    st_nxt.ind_req = 1'b0;
                    cur[IND_SUB_W-1:0] = i_ind_word[IND_SUB_W-1:0];
                    go = 1'b1;
                end
            end
            default: begin
                st_nxt.st = ST_IDLE;
            end
        endcase
        // evaluate new or substituted word
        if (go) begin
            st_nxt.ir = cur;
            m = cur[17:0];
            ea18 = {2'b00, cur.base};
            // faults touch no index register
            if (is_fault(cur)) begin
                fin = 1'b1;
            end else if (cur.ix != IX_NONE) begin
                st_nxt.st = ST_XWAIT;
                st_nxt.ready = 1'b0;
                st_nxt.xr_req = 1'b1;
                st_nxt.xr_sel = cur.ix;
            end else if (cur.ind) begin
                st_nxt.st = ST_IWAIT;
                st_nxt.ready = 1'b0;
                st_nxt.ind_req = 1'b1;
                st_nxt.ind_addr = cur.base;
            end else begin
                fin = 1'b1;
            end
        end
        // publish the result
        if (fin) begin
            st_nxt.st = ST_IDLE;
            st_nxt.ready = 1'b1;
            st_nxt.dec = decode(cur, m, ea18);
        end
    end

    // state register
    always_ff @(posedge i_sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            st_r <= '{st: ST_IDLE, ready: 1'b1, default: '0};
        end else begin
            st_r <= st_nxt;
        end
    end

    // ------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------
    assign o_ir_ready = st_r.ready;
    assign o_xr_req = st_r.xr_req;
    assign o_xr_sel = st_r.xr_sel;
    assign o_xr_wr = st_r.xr_wr;
    assign o_xr_wmod = st_r.xr_wmod;
    assign o_ind_req = st_r.ind_req;
    assign o_ind_addr = st_r.ind_addr;
    assign o_dec = st_r.dec;

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    default clocking cb @(posedge i_sys_clk); endclocking
    default disable iff (!rst_n);

    logic take;   // word accepted this cycle
    assign take = i_ir_valid && st_r.ready && st_r.st == ST_IDLE;

    field_split_a: assert property (o_dec.valid |-> o_dec.op == st_r.ir[35:30] &&
        o_dec.rnum == st_r.ir[25:22]) else $error("field split wrong");
    ext_opcode_a: assert property (o_dec.valid && o_dec.ext |->
        o_dec.ext_op == st_r.ir[35:26]) else $error("extended opcode wrong");
    fault_vector_a: assert property (o_dec.valid && o_dec.fault |->
        o_dec.ea == ERR_VEC && !o_dec.mem_rd) else $error("fault not vectored");
    imm_operand_a: assert property (o_dec.valid && !o_dec.ext &&
        o_dec.sel[3:1] == 3'b111 |-> o_dec.from_instr && o_dec.store_inh && !o_dec.mem_rd)
        else $error("immediate selector not honoured");
    sign_ext_a: assert property (o_dec.valid && !o_dec.ext |-> o_dec.sext ==
        ((o_dec.sel >= 4'h3 && o_dec.sel <= 4'h7) || o_dec.sel == 4'hf))
        else $error("sign extension wrong");
    direct_path_a: assert property (take && i_ir_word[21:18] == 4'h0 &&
        !i_ir_word[16] |=> o_dec.valid && !o_xr_req && !o_ind_req)
        else $error("direct word not decoded in one clock");
    index_req_a: assert property ($rose(o_xr_req) |-> o_xr_sel != 4'h0 &&
        !o_ir_ready) else $error("index request with zero select");
    incr_wb_a: assert property (st_r.st == ST_XWAIT && i_xr_ack |=>
        o_xr_wr == $past(st_r.ir.inc) && (!o_xr_wr || o_xr_wmod == $past(inc_sum)))
        else $error("increment write-back wrong");
    ind_subst_a: assert property (st_r.st == ST_IWAIT && i_ind_ack |=>
        st_r.ir[21:0] == $past(i_ind_word[21:0]) && st_r.ir[35:22] == $past(st_r.ir[35:22]))
        else $error("indirect substitution wrong");
    rreg_map_a: assert property (o_dec.valid && o_dec.rnum == 4'h2 |->
        o_dec.rfn == RFN_MASK) else $error("mask register not selected");
    tpa_save_a: assert property (o_dec.valid |->
        o_dec.tpa_save == $past(i_rpt_active)) else $error("temporary address save wrong");

    direct_c: cover property (take ##1 o_dec.valid);
    indexed_c: cover property (o_xr_req ##[1:20] o_xr_wr);
    indirect_c: cover property (o_ind_req ##[1:20] o_xr_req);
    fault_c: cover property (o_dec.valid && o_dec.fault);
endmodule

// *** tb/ifd_far_model.sv ***
// far-side model: index register file and core words for indirect fetches
// assumes one decoder request at a time per port
module ifd_far_model (
    // clock and reset
    input wire logic i_clk,
    input wire logic i_rst_n,
    // answer delay in cycles
    input wire logic [7:0] i_delay,
    // index register port
    input wire logic i_xr_req,
    input wire logic [3:0] i_xr_sel,
    input wire logic i_xr_wr,
    input wire logic [17:0] i_xr_wmod,
    output logic o_xr_ack,
    output logic [35:0] o_xr_word,
    // indirect fetch port
    input wire logic i_ind_req,
    input wire logic [15:0] i_ind_addr,
    output logic o_ind_ack,
    output logic [35:0] o_ind_word
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [35:0] xr_mem [0:15];    // increment high, modifier low
    logic [35:0] ind_mem [0:1023]; // small core window
    logic [7:0] xr_cnt;            // index request wait
    logic [7:0] ind_cnt;           // fetch request wait
    // -------------------------------------------------------------
    // answer each request once; idle data toggles so stale words fail
    // -------------------------------------------------------------
    always @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_xr_ack <= 1'b0;
            o_ind_ack <= 1'b0;
            o_xr_word <= '0;
            o_ind_word <= '0;
            xr_cnt <= 8'h00;
            ind_cnt <= 8'h00;
        end else begin
            o_xr_word <= ~o_xr_word;
            o_ind_word <= ~o_ind_word;
            o_xr_ack <= 1'b0;
            o_ind_ack <= 1'b0;
            xr_cnt <= (i_xr_req && !o_xr_ack) ? xr_cnt + 8'h01 : 8'h00;
            ind_cnt <= (i_ind_req && !o_ind_ack) ? ind_cnt + 8'h01 : 8'h00;
            if (i_xr_req && !o_xr_ack && xr_cnt >= i_delay) begin
                o_xr_ack <= 1'b1;
                o_xr_word <= xr_mem[i_xr_sel];
            end
            if (i_ind_req && !o_ind_ack && ind_cnt >= i_delay) begin
                o_ind_ack <= 1'b1;
                o_ind_word <= ind_mem[i_ind_addr[9:0]];
            end
            // write-back touches only the modifier half
            if (i_xr_wr) begin
                xr_mem[i_xr_sel][17:0] <= i_xr_wmod;
            end
        end
    end
endmodule

// *** tb/tb_top.sv ***
// self-checking bench for the instruction field decoder
// assumes the package and design files compile first
module tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    import ifd_pkg::*;
    // -------------------------------------------------------------
    // stimulus, design and far side
    // -------------------------------------------------------------
    logic i_sys_clk = 1'b0;
    logic i_reset_n = 1'b0;
    logic i_ir_valid = 1'b0;
    logic [35:0] i_ir_word = '0;
    logic i_rpt_active = 1'b0;
    logic [15:0] i_next_pa = 16'h0000;
    logic [7:0] far_delay = 8'h00;
    logic ir_ready, xr_req, xr_ack, xr_wr, ind_req, ind_ack;
    logic [3:0] xr_sel;
    logic [17:0] xr_wmod;
    logic [15:0] ind_addr;
    logic [35:0] xr_word, ind_word;
    ifd_dec_s dec;
    int bad_count = 0;
    int comparisons = 0;
    int cycles = 0;
    int lat;          // cycles from acceptance to result
    logic wr_seen;    // write-back pulse seen during the last word
    always #12.5 i_sys_clk = ~i_sys_clk;
    ifd_decoder u_dut (.i_sys_clk(i_sys_clk), .i_reset_n(i_reset_n), .i_ir_valid(i_ir_valid),
        .i_ir_word(i_ir_word), .o_ir_ready(ir_ready), .o_xr_req(xr_req), .o_xr_sel(xr_sel),
        .i_xr_ack(xr_ack), .i_xr_word(xr_word), .o_xr_wr(xr_wr), .o_xr_wmod(xr_wmod),
        .o_ind_req(ind_req), .o_ind_addr(ind_addr), .i_ind_ack(ind_ack),
        .i_ind_word(ind_word), .i_rpt_active(i_rpt_active), .i_next_pa(i_next_pa), .o_dec(dec));
    ifd_far_model u_far (.i_clk(i_sys_clk), .i_rst_n(i_reset_n), .i_delay(far_delay),
        .i_xr_req(xr_req), .i_xr_sel(xr_sel), .i_xr_wr(xr_wr), .i_xr_wmod(xr_wmod),
        .o_xr_ack(xr_ack), .o_xr_word(xr_word), .i_ind_req(ind_req), .i_ind_addr(ind_addr),
        .o_ind_ack(ind_ack), .o_ind_word(ind_word));
    // -------------------------------------------------------------
    // tasks: compare, offer one word, close the run
    // -------------------------------------------------------------
    task automatic test_done();
        $display("comparisons %0d bad_count %0d", comparisons, bad_count);
        if (bad_count == 0 && comparisons > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask
    task automatic chk(input string nm, input logic [35:0] exp, input logic [35:0] got);
        comparisons++;
        if (got !== exp) begin
            bad_count++;
            $display("mismatch %s expected %h seen %h", nm, exp, got);
        end
    endtask
    // offer a word for one edge, wait for the strobe
    task automatic send(input logic [35:0] w);
        int n;
        n = 0;
        wr_seen = 1'b0;
        @(posedge i_sys_clk);
        i_ir_valid <= 1'b1;
        i_ir_word <= w;
        @(posedge i_sys_clk);
        i_ir_valid <= 1'b0;
        i_ir_word <= ~w;
        @(negedge i_sys_clk);
        while (dec.valid !== 1'b1 && n < 300) begin
            wr_seen = wr_seen | (xr_wr === 1'b1);
            @(negedge i_sys_clk);
            n++;
        end
        wr_seen = wr_seen | (xr_wr === 1'b1);
        lat = n;
        if (n == 300) chk("result strobe", 1, 0);
    endtask
    function automatic logic [35:0] mk(logic [5:0] op, logic [3:0] sel, logic [3:0] rs,
        logic [3:0] ix, logic inc, logic ind, logic [15:0] base);
        return {op, sel, rs, ix, inc, ind, base};
    endfunction
    // hang guard, well above the run length
    always @(posedge i_sys_clk) begin
        cycles <= cycles + 1;
        if (cycles == 5000) begin
            bad_count++;
            test_done();
        end
    end
    // -------------------------------------------------------------
    // test sequence
    // -------------------------------------------------------------
    initial begin
        int s;
        logic [5:0] ops [4] = '{6'h01, 6'h15, 6'h20, 6'h28};
        logic [15:0] acw [3] = '{16'h001f, 16'h0020, 16'h003f};
        repeat (2) @(posedge i_sys_clk);
        i_reset_n <= 1'b1;
        repeat (3) @(posedge i_sys_clk);
        chk("ready after reset", 1, ir_ready);
        chk("result clear", 1, dec === '0);
        // every selector, direct words
        for (s = 0; s < 16; s++) begin
            send(mk(6'h01, s[3:0], 4'h5, 4'h0, 1'b1, 1'b0, 16'ha234));
            chk("latency", 0, lat);
            chk("op", 6'h01, dec.op);
            chk("sel", s, dec.sel);
            chk("rnum", 4'h5, dec.rnum);
            chk("ea", 16'ha234, dec.ea);
            chk("sext", (s >= 3 && s <= 7) || s == 15, dec.sext);
            chk("part", s == 0 ? PART_WHOLE : s < 5 ? PART_HALF : s < 8 ? PART_THIRD :
                s < 14 ? PART_SIXTH : PART_IMM, dec.part);
            chk("from word", s >= 14, dec.from_instr);
            chk("store off", s >= 14, dec.store_inh);
            chk("mem read", s < 14, dec.mem_rd);
            if (s >= 14) chk("imm", {{18{s[0]}}, 18'h2a234}, dec.imm);
        end
        @(negedge i_sys_clk);
        chk("strobe width", 0, dec.valid);
        $display("selector test done");
        // undefined codes, minor codes, index jump
        send(mk(6'h00, 4'h0, 4'h0, 4'h0, 1'b0, 1'b0, 16'h0100));
        chk("fault", 1, dec.fault);
        chk("error ea", ERR_VEC, dec.ea);
        send(mk(6'h3c, 4'h5, 4'h0, 4'h0, 1'b0, 1'b0, 16'h0100));
        chk("ext", 1, dec.ext);
        chk("ext op", {6'h3c, 4'h5}, dec.ext_op);
        chk("no fault", 0, dec.fault);
        send(mk(6'h3c, 4'h9, 4'h0, 4'h0, 1'b0, 1'b0, 16'h0100));
        chk("minor fault", 1, dec.fault);
        send(mk(6'h34, 4'h7, 4'h2, 4'h0, 1'b0, 1'b0, 16'h0000));
        chk("ij", 1, dec.ij);
        chk("ij addr", 8'h27, dec.ij_addr);
        // register groups and R functions
        for (s = 0; s < 4; s++) begin
            send(mk(ops[s], 4'h0, 4'h9, 4'h0, 1'b0, 1'b0, 16'h0000));
            chk("grp", s, dec.grp);
        end
        for (s = 0; s < 5; s++) begin
            send(mk(6'h28, 4'h0, s[3:0], 4'h0, 1'b0, 1'b0, 16'h0000));
            chk("rnum", s, dec.rnum);
            chk("rfn", s < 4 ? s : RFN_GEN, dec.rfn);
        end
        send(mk(6'h18, 4'h0, 4'h0, 4'h0, 1'b0, 1'b0, 16'h0011));
        chk("shift", 1, dec.shift);
        chk("count", 16'h0011, dec.aux);
        send(mk(6'h1c, 4'h0, 4'h0, 4'h0, 1'b0, 1'b0, 16'h0003));
        chk("lock", 1, dec.lock);
        chk("section", 16'h0003, dec.aux);
        for (s = 0; s < 3; s++) begin
            send(mk(6'h01, 4'h0, 4'h0, 4'h0, 1'b0, 1'b0, acw[s]));
            chk("acw hit", s > 0, dec.acw_hit);
        end
        @(posedge i_sys_clk);
        i_rpt_active <= 1'b1;
        i_next_pa <= 16'h4321;
        send(mk(6'h01, 4'h0, 4'h0, 4'h0, 1'b0, 1'b0, 16'h0100));
        chk("tpa save", 1, dec.tpa_save);
        chk("tpa addr", 16'h4321, dec.tpa_addr);
        @(posedge i_sys_clk);
        i_rpt_active <= 1'b0;
        send(mk(6'h01, 4'h0, 4'h0, 4'h0, 1'b0, 1'b0, 16'h0100));
        chk("no tpa save", 0, dec.tpa_save);
        $display("code test done");
        // slow index answers, increment on/off, negative modifier
        u_far.xr_mem[3] = {18'h00005, 18'h00010};
        u_far.xr_mem[4] = {18'h00000, 18'h3fffe};
        far_delay <= 8'h02;
        send(mk(6'h01, 4'h0, 4'h0, 4'h3, 1'b1, 1'b0, 16'h0100));
        chk("indexed ea", 16'h0110, dec.ea);
        chk("write back", 1, wr_seen);
        send(mk(6'h01, 4'h0, 4'h0, 4'h3, 1'b0, 1'b0, 16'h0100));
        chk("index word", {18'h00005, 18'h00015}, u_far.xr_mem[3]);
        chk("indexed ea", 16'h0115, dec.ea);
        chk("no write", 0, wr_seen);
        send(mk(6'h01, 4'h0, 4'h0, 4'h4, 1'b0, 1'b0, 16'h0010));
        chk("minus one", 16'h000f, dec.ea);
        // two-level indirect, second indexed, junk up top
        far_delay <= 8'h01;
        u_far.ind_mem[16'h0200] = {14'h3fff, 4'h0, 1'b0, 1'b1, 16'h0300};
        u_far.ind_mem[16'h0300] = {14'h3fff, 4'h3, 1'b0, 1'b0, 16'h0050};
        send(mk(6'h01, 4'h0, 4'h0, 4'h0, 1'b0, 1'b1, 16'h0200));
        chk("cascade ea", 16'h0065, dec.ea);
        chk("op kept", 6'h01, dec.op);
        chk("ready", 1, ir_ready);
        $display("address test done");
        test_done();
    end
endmodule
